// [verilog/spl_pkg.sv]
// Package with constants and types for the short-pulse input latch.
package spl_pkg;

   // ==========================================================
   // Terminal functions and layout
   // ==========================================================
   typedef enum logic [2:0] {
      SPL_FN_NORMAL,
      SPL_FN_CAPTURE,
      SPL_FN_INTERRUPT,
      SPL_FN_COUNTER_Z,
      SPL_FN_ORIGIN
   } spl_func_t;

   localparam int          SPL_NUM_TERM     = 8;
   localparam int          SPL_TERM_PER_MOD = 4;
   localparam logic [15:0] SPL_WORD_RESET   = 16'h0000;

   // Minimum ON width of a field pulse, in nanoseconds.
   localparam int SPL_MIN_ON_NS   = 30000;
   localparam int SPL_CLK_NS      = 100;
   localparam int SPL_MIN_ON_CYC  = SPL_MIN_ON_NS / SPL_CLK_NS;

   // Scan phase lengths in clock cycles, plain defaults.
   // The scan is kept longer than the shortest legal field pulse, so such
   // a pulse can start and end between two refreshes.
   localparam logic [7:0] SPL_HOUSE_CYC   = 8'h40;
   localparam logic [7:0] SPL_EXEC_CYC    = 8'hFF;
   localparam logic [7:0] SPL_REFRESH_CYC = 8'h02;
   localparam logic [7:0] SPL_PERIPH_CYC  = 8'h40;
   localparam logic [7:0] SPL_ISR_CYC     = 8'h08;

   typedef enum logic [1:0] {
      SPL_SRC_INPUT,
      SPL_SRC_COUNTER,
      SPL_SRC_TIMER
   } spl_src_t;

   // Interrupt request bundle from the three sources.
   typedef struct packed {
      logic [7:0] input_change;
      logic       counter_match;
      logic       interval_timer;
   } spl_irq_t;

   // Scan state seen outside the block.
   typedef struct packed {
      logic       refresh;
      logic       executing;
      logic       in_isr;
      logic [1:0] isr_source;
   } spl_scan_t;

endpackage : spl_pkg

// [verilog/spl_latch.sv]
// Short-pulse capture, terminal routing and scan sequencer.
module spl_latch
   import spl_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic [SPL_NUM_TERM-1:0]    terminal_in,
   input  wire spl_func_t [SPL_NUM_TERM-1:0] func_sel,
   input  wire logic                       counter_match,
   input  wire logic                       interval_timer,
   output logic [15:0]                     module0_input_status_word,
   output logic [15:0]                     module1_input_status_word,
   output logic [SPL_NUM_TERM-1:0]         normal_in,
   output logic [SPL_NUM_TERM-1:0]         irq_in,
   output logic [SPL_NUM_TERM-1:0]         counter_z_in,
   output logic [SPL_NUM_TERM-1:0]         origin_in,
   output spl_scan_t                       scan
);

   // ==========================================================
   // Startup configuration
   // ==========================================================
   spl_func_t [SPL_NUM_TERM-1:0] func_cfg;
   logic                         cfg_done;

   // Functions are caught once after reset release and then frozen.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_done <= 1'b0;
         func_cfg <= '{default: SPL_FN_NORMAL};
      end else if (!cfg_done) begin
         cfg_done <= 1'b1;
         func_cfg <= func_sel;
      end
   end

   // ==========================================================
   // Terminal routing
   // ==========================================================
   logic [SPL_NUM_TERM-1:0] sel_cap;
   logic [SPL_NUM_TERM-1:0] sel_norm;
   logic [SPL_NUM_TERM-1:0] sel_irq;
   logic [SPL_NUM_TERM-1:0] sel_cz;
   logic [SPL_NUM_TERM-1:0] sel_org;

   // One decoded enable per function, so each terminal feeds only one.
   for (genvar i = 0; i < SPL_NUM_TERM; i++) begin : g_sel
      assign sel_cap[i]  = cfg_done && func_cfg[i] == SPL_FN_CAPTURE;
      assign sel_norm[i] = cfg_done && func_cfg[i] == SPL_FN_NORMAL;
      assign sel_irq[i]  = cfg_done && func_cfg[i] == SPL_FN_INTERRUPT;
      assign sel_cz[i]   = cfg_done && func_cfg[i] == SPL_FN_COUNTER_Z;
      assign sel_org[i]  = cfg_done && func_cfg[i] == SPL_FN_ORIGIN;
   end

   // ==========================================================
   // Scan sequencer
   // ==========================================================
   typedef enum logic [2:0] {
      ST_HOUSE, ST_EXEC, ST_ISR, ST_REFRESH, ST_PERIPH
   } spl_state_t;

   spl_state_t state;
   spl_state_t next_state;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [7:0] exec_left;
   logic [7:0] next_exec_left;
   logic [1:0] isr_src;
   logic [1:0] next_isr_src;

   logic [SPL_NUM_TERM-1:0] term_q;
   logic [SPL_NUM_TERM-1:0] rise;
   logic [SPL_NUM_TERM-1:0] in_change;
   logic                    irq_any;
   logic [1:0]              irq_pick;
   logic                    cnt_done;

   // Input-change interrupts come only from terminals set to interrupt.
   assign rise      = terminal_in & ~term_q;
   assign in_change = (terminal_in ^ term_q) & sel_irq;
   assign irq_any   = |in_change || counter_match || interval_timer;
   assign irq_pick  = |in_change    ? 2'(SPL_SRC_INPUT)   :
                      counter_match ? 2'(SPL_SRC_COUNTER) :
                                      2'(SPL_SRC_TIMER);
   assign cnt_done  = cnt == 8'h00;

   // Next-state logic for the fixed scan order with interrupt entry.
   always_comb begin
      next_state     = state;
      next_cnt       = cnt_done ? cnt : 8'(cnt - 8'h01);
      next_exec_left = exec_left;
      next_isr_src   = isr_src;
      case (state)
         ST_HOUSE: begin
            if (cnt_done) begin
               next_state     = ST_EXEC;
               next_cnt       = 8'(SPL_EXEC_CYC - 8'h01);
               next_exec_left = 8'(SPL_EXEC_CYC - 8'h01);
            end
         end
         ST_EXEC: begin
            if (irq_any && cfg_done) begin
               next_state     = ST_ISR;
               next_exec_left = cnt;
               next_isr_src   = irq_pick;
               next_cnt       = 8'(SPL_ISR_CYC - 8'h01);
            end else if (cnt_done) begin
               next_state = ST_REFRESH;
               next_cnt   = 8'(SPL_REFRESH_CYC - 8'h01);
            end
         end
         ST_ISR: begin
            if (cnt_done) begin
               next_state = ST_EXEC;
               next_cnt   = exec_left;
            end
         end
         ST_REFRESH: begin
            if (cnt_done) begin
               next_state = ST_PERIPH;
               next_cnt   = 8'(SPL_PERIPH_CYC - 8'h01);
            end
         end
         ST_PERIPH: begin
            if (cnt_done) begin
               next_state = ST_HOUSE;
               next_cnt   = 8'(SPL_HOUSE_CYC - 8'h01);
            end
         end
         default: begin
            next_state = ST_HOUSE;
            next_cnt   = 8'(SPL_HOUSE_CYC - 8'h01);
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state     <= ST_HOUSE;
         cnt       <= 8'(SPL_HOUSE_CYC - 8'h01);
         exec_left <= 8'h00;
         isr_src   <= 2'h0;
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         exec_left <= next_exec_left;
         isr_src   <= next_isr_src;
      end
   end

   // ==========================================================
   // Short-pulse capture
   // ==========================================================
   logic [SPL_NUM_TERM-1:0] latch;
   logic [SPL_NUM_TERM-1:0] shown;
   logic [SPL_NUM_TERM-1:0] next_latch;
   logic [SPL_NUM_TERM-1:0] next_shown;
   logic [SPL_NUM_TERM-1:0] status;
   logic [SPL_NUM_TERM-1:0] next_status;
   logic                    refresh_end;

   assign refresh_end = state == ST_REFRESH && cnt_done;

   // A rising edge sets the latch; a refresh moves it into the status bit.
   // A bit shown at one refresh is dropped at the next unless re-armed or its input is still ON.
   assign next_latch  = refresh_end ? (rise & sel_cap)
                                    : (latch | (rise & sel_cap));
   assign next_status = refresh_end ? ((latch | terminal_in) & sel_cap)
                                    : status;
   assign next_shown  = refresh_end ? (latch & sel_cap) : shown;

   // Capture registers; no read path touches them.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         term_q <= '0;
         latch  <= '0;
         shown  <= '0;
         status <= '0;
      end else begin
         term_q <= terminal_in;
         latch  <= next_latch;
         shown  <= next_shown;
         status <= next_status;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // Status words and per-function terminal images, all registered.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         module0_input_status_word <= SPL_WORD_RESET;
         module1_input_status_word <= SPL_WORD_RESET;
         normal_in    <= '0;
         irq_in       <= '0;
         counter_z_in <= '0;
         origin_in    <= '0;
         scan         <= '0;
      end else begin
         module0_input_status_word <=
            {12'h000, next_status[3:0]};
         module1_input_status_word <=
            {12'h000, next_status[7:4]};
         normal_in    <= terminal_in & sel_norm;
         irq_in       <= terminal_in & sel_irq;
         counter_z_in <= terminal_in & sel_cz;
         origin_in    <= terminal_in & sel_org;
         scan.refresh   <= next_state == ST_REFRESH;
         scan.executing <= next_state == ST_EXEC;
         scan.in_isr    <= next_state == ST_ISR;
         scan.isr_source <= next_isr_src;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_exclusive_use: assert property (
      sel_cap[2] |=> !normal_in[2] && !irq_in[2] && !counter_z_in[2]
                      && !origin_in[2])
      else $error("Capture terminal 2 leaked to another function.");
   a_one_function: assert property (
      $onehot0({sel_cap[0], sel_norm[0], sel_irq[0], sel_cz[0], sel_org[0]}))
      else $error("Terminal 0 has more than one function.");
   a_word_map: assert property (
      ##1 module1_input_status_word[3:0] == $past(next_status[7:4]))
      else $error("Second module word does not map channels 4 to 7.");
   a_capture_gate: assert property (
      !sel_cap[1] |=> !module0_input_status_word[1])
      else $error("Non-capture terminal shows a status bit.");
   a_pulse_stored: assert property (
      refresh_end && latch[0] && sel_cap[0] |=> status[0])
      else $error("Captured pulse not stored at refresh.");
   a_refresh_clear: assert property (
      refresh_end && !latch[0] && !terminal_in[0] |=> !status[0])
      else $error("Status bit not cleared at next refresh.");
   a_scan_order: assert property (
      state == ST_REFRESH && cnt_done |=> state == ST_PERIPH)
      else $error("Refresh not followed by peripheral service.");
   a_isr_entry: assert property (
      state == ST_EXEC && irq_any && cfg_done |=> state == ST_ISR)
      else $error("Interrupt did not suspend execution.");
   a_isr_return: assert property (
      state == ST_ISR && cnt_done |=> state == ST_EXEC
         && cnt == $past(exec_left))
      else $error("Interrupt return lost the execution point.");
   a_latch_hold: assert property (
      latch[2] && !refresh_end |=> latch[2])
      else $error("Latch dropped outside a refresh.");

   c_capture: cover property (refresh_end && latch[2] && sel_cap[2]);
   c_isr: cover property (state == ST_ISR && isr_src == 2'(SPL_SRC_TIMER));
   c_full_scan: cover property (state == ST_PERIPH ##1 state == ST_HOUSE);
   c_resume: cover property (state == ST_ISR ##1 state == ST_EXEC);

endmodule : spl_latch

// [testbench/spl_field_sensor.sv]
// Field sensor model that drives the eight discrete input terminals.
module spl_field_sensor
   import spl_pkg::*;
(
   input  wire logic                clk,
   output logic [SPL_NUM_TERM-1:0]  terminal_in
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // Level and pulse drivers
   // ==========================================================
   initial terminal_in = 8'h00;

   // Sets new levels just after a falling edge.
   task automatic drive(input logic [7:0] lv);
      @(negedge clk);
      terminal_in = lv;
   endtask : drive

   // Holds an ON pulse for the given cycles, never below the legal minimum.
   task automatic pulse(input logic [7:0] m, input int cyc);
      int hold;
      hold = (cyc < SPL_MIN_ON_CYC) ? SPL_MIN_ON_CYC : cyc;
      drive(m);
      repeat (hold) @(negedge clk);
      terminal_in = 8'h00;
   endtask : pulse
endmodule : spl_field_sensor

// [testbench/tb_spl_latch.sv]
// Self-checking bench for the short-pulse input latch.
module tb_spl_latch
   import spl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // Signals and instances
   // ==========================================================
   logic                        clk = 1'b0;
   logic                        rstn = 1'b0;
   logic [SPL_NUM_TERM-1:0]     terminal_in;
   spl_func_t [SPL_NUM_TERM-1:0] func_sel;
   logic                        counter_match = 1'b0;
   logic                        interval_timer = 1'b0;
   logic [15:0]                 w0, w1;
   logic [SPL_NUM_TERM-1:0]     normal_in, irq_in, counter_z_in, origin_in;
   spl_scan_t                   scan;
   int                          n_fail = 0, cmp_count = 0, ex_n = 0;
   spl_func_t [7:0]             cap = '{default: SPL_FN_CAPTURE};
   spl_func_t [7:0]             mix = '{SPL_FN_CAPTURE, SPL_FN_INTERRUPT,
      SPL_FN_NORMAL, SPL_FN_CAPTURE, SPL_FN_ORIGIN, SPL_FN_COUNTER_Z,
      SPL_FN_INTERRUPT, SPL_FN_NORMAL};

   always #50 clk = ~clk;

   // Counts sampled cycles of cyclic program execution.
   always @(negedge clk) if (scan.executing === 1'b1) ex_n <= ex_n + 1;

   spl_field_sensor spl_field_sensor_i (.clk(clk), .terminal_in(terminal_in));

   spl_latch spl_latch_i (
      .clk(clk), .rstn(rstn), .terminal_in(terminal_in),
      .func_sel(func_sel), .counter_match(counter_match),
      .interval_timer(interval_timer), .module0_input_status_word(w0),
      .module1_input_status_word(w1), .normal_in(normal_in),
      .irq_in(irq_in), .counter_z_in(counter_z_in),
      .origin_in(origin_in), .scan(scan));

   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic report_and_stop();
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   // Counts falling edges while one scan flag keeps the given value.
   task automatic run_len(input int b, input logic v, output int n);
      n = 0;
      while (scan[b] === v && n < 400) begin
         @(negedge clk);
         n++;
      end
   endtask : run_len

   // Steps to two cycles after the end of the next refresh.
   task automatic next_ref();
      int k;
      run_len(4, 1'b1, k);
      run_len(4, 1'b0, k);
      run_len(4, 1'b1, k);
      repeat (2) @(negedge clk);
   endtask : next_ref

   // Applies a terminal setup and restarts the block.
   task automatic do_reset(input spl_func_t [7:0] cfg);
      rstn = 1'b0;
      func_sel = cfg;
      repeat (10) @(negedge clk);
      chk("word0 reset", SPL_WORD_RESET, w0);
      chk("word1 reset", SPL_WORD_RESET, w1);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
   endtask : do_reset

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_order();
      int n;
      run_len(4, 1'b0, n);
      run_len(4, 1'b1, n);
      run_len(3, 1'b0, n);
      chk("periph+house", 16'(SPL_PERIPH_CYC + SPL_HOUSE_CYC),
          16'(n));
      run_len(3, 1'b1, n);
      chk("exec len", 16'(SPL_EXEC_CYC), 16'(n));
      run_len(4, 1'b0, n);
      chk("exec to refresh", 16'h0000, 16'(n));
      run_len(4, 1'b1, n);
      chk("refresh len", 16'(SPL_REFRESH_CYC), 16'(n));
   endtask : t_order

   task automatic t_capture();
      int k;
      // Start just after a refresh, so a legal pulse ends before the next.
      run_len(4, 1'b0, k);
      run_len(4, 1'b1, k);
      spl_field_sensor_i.pulse(8'hA5, SPL_MIN_ON_CYC);
      next_ref();
      chk("word0 set", 16'h0005, w0);
      chk("word1 set", 16'h000A, w1);
      next_ref();
      chk("word0 clear", 16'h0000, w0);
      chk("word1 clear", 16'h0000, w1);
      fork
         spl_field_sensor_i.pulse(8'h04, SPL_MIN_ON_CYC);
         begin
            repeat (100) @(negedge clk);
            chk("ch2 others", 16'h0000,
                16'(normal_in | irq_in | counter_z_in | origin_in));
            // No refresh has passed yet, so nothing is presented.
            chk("ch2 early", 16'h0000, w0);
         end
      join
      next_ref();
      chk("ch2 held", 16'h0004, w0);
      next_ref();
      chk("ch2 clear", 16'h0000, w0);
   endtask : t_capture

   task automatic t_route();
      spl_field_sensor_i.drive(8'hFF);
      repeat (3) @(negedge clk);
      chk("normal", 16'h0021, 16'(normal_in));
      chk("irq", 16'h0042, 16'(irq_in));
      chk("counter z", 16'h0004, 16'(counter_z_in));
      chk("origin", 16'h0008, 16'(origin_in));
      next_ref();
      chk("word0 no capture", 16'h0000, w0);
      chk("word1 capture", 16'h0009, w1);
      spl_field_sensor_i.drive(8'h00);
      next_ref();
      next_ref();
   endtask : t_route

   task automatic t_irq();
      int k, e0, s;
      for (int i = 1; i < 4; i++) begin
         s = i % 3;
         run_len(3, 1'b1, k);
         e0 = ex_n;
         run_len(3, 1'b0, k);
         repeat (3) @(negedge clk);
         if (s == 0) spl_field_sensor_i.drive(8'h02);
         else if (s == 1) counter_match = 1'b1;
         else interval_timer = 1'b1;
         @(negedge clk);
         counter_match = 1'b0;
         interval_timer = 1'b0;
         run_len(2, 1'b0, k);
         chk("isr source", 16'(s), 16'(scan.isr_source));
         chk("exec suspended", 16'h0000, 16'(scan.executing));
         run_len(2, 1'b1, k);
         chk("isr len", 16'(SPL_ISR_CYC), 16'(k));
         run_len(4, 1'b0, k);
         // The step cut by the request is run again after the return.
         chk("exec resumed", 16'(SPL_EXEC_CYC) + 16'h0001,
             16'(ex_n - e0));
      end
      spl_field_sensor_i.drive(8'h00);
   endtask : t_irq

   // ==========================================================
   // Main sequence and watchdog
   // ==========================================================
   initial begin
      func_sel = cap;
      do_reset(cap);
      t_order();
      t_capture();
      do_reset(mix);
      t_route();
      t_irq();
      report_and_stop();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end
endmodule : tb_spl_latch
